/* logic/astx_pkg.sv */
package astx_pkg;
	// character framing
	localparam int DATA_BITS_8 = 8;
	localparam int DATA_BITS_9 = 9;
	localparam int RT_PER_BIT = 16;
	localparam logic [3:0] RT_START_A = 4'h2;
	localparam logic [3:0] RT_START_B = 4'h4;
	localparam logic [3:0] RT_START_C = 4'h6;
	localparam logic [3:0] RT_MID_A = 4'h7;
	localparam logic [3:0] RT_MID_B = 4'h8;
	localparam logic [3:0] RT_MID_C = 4'h9;
	localparam logic [3:0] RT_LAST = 4'hF;
	localparam logic [15:0] BAUD_DIV_RESET = 16'h0036;
	localparam logic [8:0] DATA_RESET = 9'h000;

	// control inputs gathered together
	typedef struct packed {
		logic module_enable;
		logic tx_enable;
		logic send_break;
		logic nine_bit;
		logic tx_empty_irq_enable;
		logic tx_complete_irq_enable;
		logic rx_full_irq_enable;
	} astx_ctrl_type;

	// receiver status flags
	typedef struct packed {
		logic rx_full_flag;
		logic framing_error_flag;
		logic noise_flag;
		logic break_detected_flag;
		logic overrun_flag;
		logic rx_in_progress_flag;
	} astx_rx_flags_type;

	typedef enum logic [1:0] {TX_IDLE, TX_PREAMBLE, TX_SHIFT, TX_BREAK} astx_tx_state_type;
	typedef enum logic [1:0] {RX_SEARCH, RX_START, RX_DATA, RX_STOP} astx_rx_state_type;
endpackage

/* logic/astx_tick.sv */
`timescale 1ns/1ps
// divider making the 16x sample tick from the system clock
module astx_tick import astx_pkg::*; #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic run,
	input wire logic [WIDTH-1:0] divisor,
	output logic tick
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic tick;
	} astx_tick_state_type;
	astx_tick_state_type st, next_st;

	// count down, pulse at terminal count
	always_comb
	begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!run)
			next_st.count = '0;
		else if (st.count == '0)
		begin
			next_st.count = divisor;
			next_st.tick = 1'b1;
		end
		else
			next_st.count = st.count - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			st <= '0;
		else if (ce)
			st <= next_st;
	end

	assign tick = st.tick & ce;
endmodule // astx_tick

/* logic/astx_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for the receive pin
module astx_sync import astx_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic first;
		logic second;
	} astx_sync_state_type;
	astx_sync_state_type st, next_st;

	always_comb
	begin
		next_st.first = din;
		next_st.second = st.first;
	end

	// resets to idle level
	always_ff @(posedge clk)
	begin
		if (!resetn)
			st <= 2'b11;
		else if (ce)
			st <= next_st;
	end

	assign dout = st.second;
endmodule // astx_sync

/* logic/astx_core.sv */
`timescale 1ns/1ps
// Function
// - eight or nine bit characters both ways
// - first send an idle preamble; break instead if send_break set, none if tx_enable rose while module disabled
// - start zero low, stop one high
// - buffer empty sets on hand-over, interrupts
// - line idles high between characters
// - module disable releases both pins
// - send break repeats all-zero characters
// - after break, send at least one one
// - break is start, zeros, zero stop
// - break sets flags, clears data buffer
// - transmit disable idles; toggle queues idle
// - complete when shifter, buffer empty, idle
// - received data to buffer, full flag
// - sample line at sixteen times baud
// - resynchronise after start and falling edges
// - start search: zero after three ones
// - start check samples three, five, seven
// - data bit majority of eight-nine-ten
// - ones late in start bit mean noise
// - stop sampled; zero majority framing error
module astx_core import astx_pkg::*; #(
	parameter int DIV_WIDTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire astx_ctrl_type ctrl,
	input wire logic [DIV_WIDTH-1:0] baud_div,
	input wire logic [8:0] tx_data,
	input wire logic tx_write,
	input wire logic rx_read,
	input wire logic rx_pin,
	output logic tx_out,
	output logic tx_oe,
	output logic rx_pin_owned,
	output logic [8:0] rx_data,
	output astx_rx_flags_type rx_flags,
	output logic tx_buffer_empty_flag,
	output logic tx_complete_flag,
	output logic tx_irq,
	output logic rx_irq
);
	typedef struct packed {
		astx_tx_state_type tx_state;
		logic [10:0] tx_shift;
		logic [3:0] tx_bits;
		logic [3:0] tx_rt;
		logic [8:0] tx_buf;
		logic tx_buf_full;
		logic te_last;
		logic idle_queued;
		logic tx_line;
		astx_rx_state_type rx_state;
		logic [3:0] rx_rt;
		logic [2:0] rx_hist;
		logic [2:0] rx_smp;
		logic [3:0] rx_bits;
		logic [8:0] rx_shift;
		logic rx_noise;
		logic rx_prev_bit;
		logic rx_last;
		logic [3:0] rx_edge_rt;
		logic [8:0] rx_data;
		astx_rx_flags_type flags;
	} astx_core_state_type;
	astx_core_state_type st, next_st;

	logic tick;
	logic rx_s;
	logic [3:0] char_bits;
	logic maj;
	logic agree;

	// sample tick at 16x baud
	astx_tick #(.WIDTH(DIV_WIDTH)) u_tick (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.run(ctrl.module_enable),
		.divisor(baud_div),
		.tick(tick)
	);

	astx_sync u_sync (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.din(rx_pin),
		.dout(rx_s)
	);

	// framed length: data plus start and stop
	assign char_bits = ctrl.nine_bit ? 4'(DATA_BITS_9 + 2) : 4'(DATA_BITS_8 + 2);
	assign maj = (st.rx_smp[0] & st.rx_smp[1]) | (st.rx_smp[0] & rx_s) | (st.rx_smp[1] & rx_s);
	assign agree = (st.rx_smp[0] == st.rx_smp[1]) && (st.rx_smp[1] == rx_s);

	// transmitter and receiver next state
	always_comb
	begin
		next_st = st;
		// buffer write by software
		if (tx_write)
		begin
			next_st.tx_buf = tx_data;
			next_st.tx_buf_full = 1'b1;
		end
		// toggle of enable queues an idle character
		next_st.te_last = ctrl.tx_enable;
		if (ctrl.tx_enable && !st.te_last && st.tx_state != TX_IDLE)
			next_st.idle_queued = 1'b1;
		if (tick)
		begin
			next_st.tx_rt = st.tx_rt + 4'h1;
			if (st.tx_rt == RT_LAST)
			begin
				next_st.tx_line = st.tx_shift[0];
				next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
				next_st.tx_bits = st.tx_bits - 4'h1;
				if (st.tx_bits <= 4'h1)
				begin
					// character done: choose the next one
					next_st.tx_state = TX_IDLE;
					next_st.tx_bits = 4'h0; // stay on a bit boundary while idle
					if (!ctrl.module_enable || !ctrl.tx_enable)
						next_st.tx_state = TX_IDLE;
					else if (ctrl.send_break)
					begin
						next_st.tx_state = TX_BREAK;
						next_st.tx_shift = '0;
						next_st.tx_bits = char_bits;
					end
					else if (st.tx_state == TX_BREAK || st.idle_queued)
					begin
						// trailing ones after break, or queued idle
						next_st.tx_state = TX_PREAMBLE;
						next_st.tx_shift = '1;
						next_st.tx_bits = st.tx_state == TX_BREAK ? 4'h1 : char_bits;
						next_st.idle_queued = 1'b0;
					end
					else if (st.tx_buf_full && !tx_write)
					begin
						// start low, stop high
						next_st.tx_state = TX_SHIFT;
						next_st.tx_shift = ctrl.nine_bit ? {1'b1, st.tx_buf, 1'b0}
							: {2'b11, st.tx_buf[7:0], 1'b0};
						next_st.tx_bits = char_bits;
						next_st.tx_buf_full = 1'b0;
					end
				end
			end
		end
		// start of transmission with preamble, or with break if send_break is set
		if (st.tx_state == TX_IDLE && ctrl.module_enable && ctrl.tx_enable
			&& (!st.te_last || ctrl.send_break))
		begin
			next_st.tx_state = ctrl.send_break ? TX_BREAK : TX_PREAMBLE;
			next_st.tx_shift = ctrl.send_break ? '0 : '1;
			next_st.tx_bits = char_bits;
			next_st.tx_rt = 4'h0;
			next_st.idle_queued = 1'b0;
		end
		if (st.tx_state == TX_IDLE)
			next_st.tx_line = 1'b1;
		// receiver
		if (rx_read)
			next_st.flags.rx_full_flag = 1'b0;
		if (tick)
		begin
			next_st.rx_rt = st.rx_rt + 4'h1;
			case (st.rx_state)
				RX_SEARCH:
				begin
					next_st.rx_hist = {st.rx_hist[1:0], rx_s};
					// zero after three ones
					if (!rx_s && st.rx_hist == 3'b111)
					begin
						next_st.rx_state = RX_START;
						next_st.rx_rt = 4'h1;
						next_st.rx_noise = 1'b0;
						next_st.flags.rx_in_progress_flag = 1'b1;
					end
				end
				RX_START:
				begin
					if (st.rx_rt == RT_START_A)
						next_st.rx_smp[0] = rx_s;
					if (st.rx_rt == RT_START_B)
						next_st.rx_smp[1] = rx_s;
					if (st.rx_rt == RT_START_C)
					begin
						// verify start: at most one high sample
						if ((st.rx_smp[0] + st.rx_smp[1] + rx_s) > 2'd1)
						begin
							next_st.rx_state = RX_SEARCH;
							next_st.rx_hist = 3'b000;
							next_st.rx_rt = 4'h0;
							next_st.flags.rx_in_progress_flag = 1'b0;
						end
						else if (st.rx_smp[0] | st.rx_smp[1] | rx_s)
							next_st.rx_noise = 1'b1;
					end
					// late ones in start only flag noise
					if ((st.rx_rt >= RT_MID_A) && (st.rx_rt <= RT_MID_C) && rx_s)
						next_st.rx_noise = 1'b1;
					if (st.rx_rt == RT_LAST)
					begin
						next_st.rx_state = RX_DATA;
						next_st.rx_bits = 4'h0;
						next_st.rx_prev_bit = 1'b0;
					end
				end
				RX_DATA, RX_STOP:
				begin
					// age of the latest falling edge, for resync
					next_st.rx_last = rx_s;
					next_st.rx_edge_rt = (st.rx_last && !rx_s) ? 4'h1 : st.rx_edge_rt + 4'h1;
					if (st.rx_rt == RT_MID_A)
						next_st.rx_smp[0] = rx_s;
					if (st.rx_rt == RT_MID_B)
						next_st.rx_smp[1] = rx_s;
					if (st.rx_rt == RT_MID_C)
					begin
						if (!agree)
							next_st.rx_noise = 1'b1;
						if (st.rx_state == RX_DATA)
						begin
							// majority vote, shift in LSB first
							next_st.rx_shift = ctrl.nine_bit ? {maj, st.rx_shift[8:1]}
								: {1'b0, maj, st.rx_shift[7:1]};
							next_st.rx_prev_bit = maj;
							next_st.rx_bits = st.rx_bits + 4'h1;
							// resync on one-to-zero change
							if (st.rx_prev_bit && !maj)
								next_st.rx_rt = st.rx_edge_rt + 4'h1;
							if (st.rx_bits + 4'h1 == char_bits - 4'h2)
								next_st.rx_state = RX_STOP;
						end
						else
						begin
							// character complete
							next_st.rx_state = RX_SEARCH;
							next_st.rx_hist = 3'b000;
							next_st.flags.rx_in_progress_flag = 1'b0;
							next_st.flags.overrun_flag = st.flags.rx_full_flag & !rx_read;
							next_st.flags.rx_full_flag = 1'b1;
							next_st.flags.framing_error_flag = !maj;
							next_st.flags.noise_flag = st.rx_noise | !agree;
							next_st.flags.break_detected_flag = 1'b0;
							// 8-bit: ninth mirrors bit 7
							next_st.rx_data = ctrl.nine_bit ? st.rx_shift
								: {st.rx_shift[7], st.rx_shift[7:0]};
							// all zeros plus zero stop is a break
							if (!maj && st.rx_shift == DATA_RESET)
							begin
								next_st.rx_data = DATA_RESET;
								next_st.flags.break_detected_flag = 1'b1;
							end
						end
					end
				end
				default:
					next_st.rx_state = RX_SEARCH;
			endcase
		end
		// module disable stops transmitter and receiver
		if (!ctrl.module_enable)
		begin
			next_st.tx_state = TX_IDLE;
			next_st.tx_line = 1'b1;
			next_st.rx_state = RX_SEARCH;
			next_st.flags.rx_in_progress_flag = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st <= '0;
			st.tx_line <= 1'b1;
			st.rx_data <= DATA_RESET;
		end
		else if (ce)
			st <= next_st;
	end

	// pins released when the module is disabled
	assign tx_out = st.tx_line;
	assign tx_oe = ctrl.module_enable;
	assign rx_pin_owned = ctrl.module_enable;
	assign rx_data = st.rx_data;
	assign rx_flags = st.flags;
	assign tx_buffer_empty_flag = !st.tx_buf_full;
	assign tx_complete_flag = !st.tx_buf_full && st.tx_state == TX_IDLE;
	assign tx_irq = (ctrl.tx_empty_irq_enable & tx_buffer_empty_flag)
		| (ctrl.tx_complete_irq_enable & tx_complete_flag);
	assign rx_irq = ctrl.rx_full_irq_enable & st.flags.rx_full_flag;

	chk_idle_line_high: assert property (@(posedge clk) disable iff (!resetn)
		st.tx_state == TX_IDLE && $past(st.tx_state) == TX_IDLE |-> tx_out)
		else $error("line not idle high");
	chk_break_zero_line: assert property (@(posedge clk) disable iff (!resetn)
		st.tx_state == TX_BREAK && $past(st.tx_state) == TX_BREAK
		&& $past(st.tx_state, 2) == TX_BREAK && $past(tick) |-> !st.tx_shift[0])
		else $error("break shifter not zero");
	chk_release_pins: assert property (@(posedge clk) disable iff (!resetn)
		!ctrl.module_enable |-> !tx_oe && !rx_pin_owned)
		else $error("pins held while disabled");
	chk_complete_flag: assert property (@(posedge clk) disable iff (!resetn)
		tx_complete_flag |-> tx_buffer_empty_flag && st.tx_state == TX_IDLE)
		else $error("complete with work pending");
	chk_rx_irq_full: assert property (@(posedge clk) disable iff (!resetn)
		rx_irq |-> st.flags.rx_full_flag && ctrl.rx_full_irq_enable)
		else $error("rx irq without full");
	chk_break_clears_data: assert property (@(posedge clk) disable iff (!resetn)
		$rose(st.flags.break_detected_flag) |-> st.rx_data == DATA_RESET
		&& st.flags.framing_error_flag && st.flags.rx_full_flag)
		else $error("break effects missing");
	chk_start_sample: assert property (@(posedge clk) disable iff (!resetn || !ce)
		st.rx_state == RX_SEARCH && tick && !rx_s && st.rx_hist == 3'b111
		&& ctrl.module_enable |=> st.rx_state == RX_START)
		else $error("start edge missed");
	chk_ninth_mirror: assert property (@(posedge clk) disable iff (!resetn)
		$changed(st.rx_data) && !ctrl.nine_bit |-> st.rx_data[8] == st.rx_data[7])
		else $error("ninth bit not mirror");
	chk_tx_empty_irq: assert property (@(posedge clk) disable iff (!resetn)
		$rose(tx_buffer_empty_flag) |-> st.tx_state == TX_SHIFT
		&& (tx_irq || !ctrl.tx_empty_irq_enable))
		else $error("buffer empty without hand-over");
	cov_break_rx: cover property (@(posedge clk) $rose(st.flags.break_detected_flag));
	cov_char_rx: cover property (@(posedge clk) $rose(st.flags.rx_full_flag));
	cov_tx_break: cover property (@(posedge clk) st.tx_state == TX_BREAK);
	cov_noise: cover property (@(posedge clk) $rose(st.flags.noise_flag));
endmodule // astx_core

/* tb/astx_remote.sv */
`timescale 1ns/1ps
// far-end serial device: drives our receive pin and reads our transmit line
module astx_remote #(
	parameter int BT = 64
) (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	// the line rests at mark level between frames
	initial line_out = 1'b1;

	// start, n data bits lsb first, stop; bit g is inverted for one sample period
	task automatic send(input logic [8:0] d, input int n, input logic stop, input int g);
		logic v;
		for (int i = -1; i <= n; i++)
		begin
			v = (i < 0) ? 1'b0 : (i == n) ? stop : d[i];
			@(posedge clk);
			#1 line_out = v;
			repeat (36) @(posedge clk);
			#1 line_out = (i == g) ? !v : v;
			repeat (4) @(posedge clk);
			#1 line_out = v;
			repeat (BT - 41) @(posedge clk);
		end
		@(posedge clk);
		#1 line_out = 1'b1;
	endtask

	// short low pulse on an idle line
	task automatic pulse_low(input int len);
		@(posedge clk);
		#1 line_out = 1'b0;
		repeat (len) @(posedge clk);
		#1 line_out = 1'b1;
	endtask

	// wait for a start bit, then sample every bit in its middle
	task automatic capture(input int n, output logic [10:0] bits, output int w);
		bits = '1;
		w = 0;
		while (line_in === 1'b1 && w < 40 * BT)
		begin
			@(posedge clk);
			w++;
		end
		repeat (BT / 2) @(posedge clk);
		for (int i = 0; i <= n + 1; i++)
		begin
			bits[i] = line_in;
			repeat (BT) @(posedge clk);
		end
		#1;
	endtask
endmodule // astx_remote

/* tb/test_async_serial_tx_rx_core.sv */
`timescale 1ns/1ps
// self-checking bench for the serial core
module test_async_serial_tx_rx_core import astx_pkg::*;;
	localparam int BT = 64;
	logic clk, resetn, ce, tx_write, rx_read, rx_pin, tx_out, tx_oe, rx_pin_owned;
	logic tx_buffer_empty_flag, tx_complete_flag, tx_irq, rx_irq;
	astx_ctrl_type ctrl;
	astx_rx_flags_type rx_flags;
	logic [15:0] baud_div;
	logic [8:0] tx_data, rx_data;
	logic [10:0] bits;
	int err_count, check_count, w, cnt, lw;

	// system clock, 10 ns period
	always #5 clk = ~clk;

	astx_core DUT (.clk, .resetn, .ce, .ctrl, .baud_div, .tx_data, .tx_write, .rx_read,
		.rx_pin, .tx_out, .tx_oe, .rx_pin_owned, .rx_data, .rx_flags,
		.tx_buffer_empty_flag, .tx_complete_flag, .tx_irq, .rx_irq);
	astx_remote #(.BT(BT)) remote (.clk, .line_in(tx_out), .line_out(rx_pin));

	task automatic step;
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// load the transmit buffer with one pulse
	task automatic write(input logic [8:0] d);
		tx_data = d;
		tx_write = 1'b1;
		step;
		tx_write = 1'b0;
	endtask

	// one received character, its flags, then the software read
	task automatic rx_case(input logic [8:0] d, input int n, input logic stop, input int g,
			input logic [8:0] ed, input logic [1:0] ef, input int nf);
		remote.send(d, n, stop, g);
		chk("rx_full", 1, rx_flags.rx_full_flag);
		chk("rx_irq", 1, rx_irq);
		chk("rx_data", ed, rx_data);
		chk("fe_break", ef, {rx_flags.framing_error_flag, rx_flags.break_detected_flag});
		if (nf >= 0)
			chk("noise", nf[0], rx_flags.noise_flag);
		rx_read = 1'b1;
		step;
		rx_read = 1'b0;
		repeat (2 * BT) step;
		chk("rx_full", 0, rx_flags.rx_full_flag);
	endtask

	// whole-run limit
	initial
	begin
		repeat (100000) @(posedge clk);
		err_count++;
		$display("CHECK FAILED run_limit expected end seen timeout");
		give_verdict;
	end

	// main sequence
	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		ce = 1'b1;
		ctrl = '0;
		baud_div = 16'h0003; // 64 clocks a bit, above 32 per bit
		tx_data = 9'h000;
		tx_write = 1'b0;
		rx_read = 1'b0;
		err_count = 0;
		check_count = 0;
		repeat (8) @(posedge clk);
		#1 resetn = 1'b1;
		step;
		chk("tx_out", 1, tx_out);
		chk("tx_empty", 1, tx_buffer_empty_flag);
		chk("tx_done", 1, tx_complete_flag);
		chk("rx_data", 0, rx_data);
		chk("rx_flags", 0, rx_flags);
		chk("pins", 0, {tx_oe, rx_pin_owned});
		$display("test reset done");
		ctrl.module_enable = 1'b1;
		step;
		ctrl.tx_enable = 1'b1;
		ctrl.tx_empty_irq_enable = 1'b1;
		step;
		chk("pins", 3, {tx_oe, rx_pin_owned});
		chk("tx_irq", 1, tx_irq);
		write(9'h0A5);
		chk("tx_empty", 0, tx_buffer_empty_flag);
		chk("tx_irq", 0, tx_irq);
		capture_chk: begin end
		remote.capture(8, bits, w);
		chk("preamble", 1, w >= 9 * BT && w < 40 * BT);
		chk("frame", {2'b11, 8'hA5, 1'b0}, bits);
		chk("tx_empty", 1, tx_buffer_empty_flag);
		chk("tx_done", 1, tx_complete_flag);
		ctrl.nine_bit = 1'b1;
		write(9'h15A);
		remote.capture(9, bits, w);
		chk("frame9", {1'b1, 9'h15A, 1'b0}, bits);
		ctrl.tx_empty_irq_enable = 1'b0;
		ctrl.tx_complete_irq_enable = 1'b1;
		step;
		chk("tc_irq", 1, tx_irq);
		$display("test transmit done");
		// enable toggled inside a character queues an idle character
		ctrl.nine_bit = 1'b0;
		write(9'h033);
		fork
			remote.capture(8, bits, w);
			begin
				repeat (4 * BT) step;
				write(9'h055);
				ctrl.tx_enable = 1'b0;
				step;
				ctrl.tx_enable = 1'b1;
			end
		join
		chk("frame", {2'b11, 8'h33, 1'b0}, bits);
		remote.capture(8, bits, w);
		chk("idle_gap", 1, w >= 9 * BT && w < 40 * BT);
		chk("frame", {2'b11, 8'h55, 1'b0}, bits);
		// break held for three bit times, then a queued character
		ctrl.send_break = 1'b1;
		lw = 0;
		while (tx_out !== 1'b0 && lw < 40 * BT)
		begin
			step;
			lw++;
		end
		chk("break_start", 1, lw < 40 * BT);
		cnt = 0;
		while (tx_out === 1'b0 && cnt < 40 * BT)
		begin
			if (cnt == 3 * BT)
			begin
				chk("tx_done", 0, tx_complete_flag);
				ctrl.send_break = 1'b0;
				tx_data = 9'h00F;
				tx_write = 1'b1;
			end
			step;
			tx_write = 1'b0;
			cnt++;
		end
		chk("break_len", 1, cnt > 10 * BT - 4 && cnt < 10 * BT + 4);
		cnt = 0;
		while (tx_out === 1'b1 && cnt < 40 * BT)
		begin
			step;
			cnt++;
		end
		chk("break_mark", 1, cnt >= BT - 2 && cnt < 40 * BT);
		remote.capture(8, bits, w);
		chk("frame", {2'b11, 8'h0F, 1'b0}, bits);
		// enable cleared mid-character: line idles afterwards
		write(9'h066);
		fork
			remote.capture(8, bits, w);
			begin
				repeat (4 * BT) step;
				write(9'h077);
				ctrl.tx_enable = 1'b0;
			end
		join
		chk("frame", {2'b11, 8'h66, 1'b0}, bits);
		cnt = 0;
		repeat (20 * BT)
		begin
			step;
			cnt += (tx_out !== 1'b1);
		end
		chk("idle_line", 1, cnt == 0);
		$display("test break and idle done");
		// receive path: rejected start, clean, noisy, framing and break cases
		ctrl.rx_full_irq_enable = 1'b1;
		remote.pulse_low(8);
		repeat (12 * BT) step;
		chk("rx_full", 0, rx_flags.rx_full_flag);
		rx_case(9'h0B6, 8, 1'b1, 99, 9'h1B6, 2'b00, 0);
		rx_case(9'h03C, 8, 1'b1, -1, 9'h03C, 2'b00, 1);
		rx_case(9'h0AA, 8, 1'b1, 8, 9'h1AA, 2'b00, 1);
		rx_case(9'h055, 8, 1'b0, 99, 9'h055, 2'b10, 0);
		rx_case(9'h000, 8, 1'b0, 99, 9'h000, 2'b11, -1);
		ctrl.nine_bit = 1'b1;
		rx_case(9'h101, 9, 1'b1, 99, 9'h101, 2'b00, 0);
		rx_case(9'h0F0, 9, 1'b1, 3, 9'h0F0, 2'b00, 1);
		$display("test receive done");
		ctrl.module_enable = 1'b0;
		step;
		chk("pins", 0, {tx_oe, rx_pin_owned});
		$display("test disable done");
		give_verdict;
	end
endmodule // test_async_serial_tx_rx_core
